// ---- tcvc_pkg.sv ----
// constants, types and helpers of the thermocouple value correction block
package tcvc_pkg;
    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ = 200_000_000; // core clock rate
    localparam int unsigned MEAS_PER_CH = 3; // tc voltage, wire check, cold junction
    localparam int unsigned FILT_HZ_0 = 50; // notch frequency, code 0
    localparam int unsigned FILT_HZ_1 = 60; // notch frequency, code 1
    localparam int unsigned FILT_HZ_2 = 100; // notch frequency, code 2
    localparam int unsigned FILT_HZ_3 = 500; // notch frequency, code 3
    localparam int unsigned FILT_CYC_0 = CLK_HZ / FILT_HZ_0; // one filter period
    localparam int unsigned FILT_CYC_1 = CLK_HZ / FILT_HZ_1;
    localparam int unsigned FILT_CYC_2 = CLK_HZ / FILT_HZ_2;
    localparam int unsigned FILT_CYC_3 = CLK_HZ / FILT_HZ_3;
    localparam int unsigned CALC_TIME_US = 6000; // computing time per cycle
    localparam int unsigned CALC_CYC = (CLK_HZ / 1_000_000) * CALC_TIME_US;
    ////////////////////////////////////////////////////////////////////////
    // register index inside a channel block (address bits 3:0)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_LIM1 = 4'h1;
    localparam logic [3:0] REG_LIM2 = 4'h2;
    localparam logic [3:0] REG_SCL_OFS = 4'h3;
    localparam logic [3:0] REG_SCL_GAIN = 4'h4;
    localparam logic [3:0] REG_UCAL_OFS = 4'h5;
    localparam logic [3:0] REG_UCAL_GAIN = 4'h6;
    localparam logic [3:0] REG_EXT_CJ = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_VALUE = 4'h9;
    localparam logic [3:0] REG_RAW_TC = 4'ha;
    localparam logic [3:0] REG_RAW_CJ = 4'hb;
    localparam logic [3:0] REG_FCAL_OFS = 4'hc;
    localparam logic [3:0] REG_FCAL_GAIN = 4'hd;
    localparam logic [3:0] REG_FCAL_CJ = 4'he;
    ////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int CTRL_SCL_EN = 0; // user scaling enable
    localparam int CTRL_UCAL_EN = 1; // user calibration enable
    localparam int CTRL_FCAL_EN = 2; // factory calibration enable
    localparam int CTRL_FILT_EN = 3; // filter enable, stored only
    localparam int CTRL_CJ_LO = 4; // cold junction source, 2 bits
    localparam int CTRL_FILT_LO = 8; // filter code, 2 bits
    localparam logic [1:0] CJ_SRC_EXT = 2'h2; // master supplies cj temperature
    // status field positions
    localparam int ST_UNDER = 0;
    localparam int ST_OVER = 1;
    localparam int ST_LIM1_LO = 2;
    localparam int ST_LIM2_LO = 4;
    localparam int ST_ERR = 6;
    localparam int ST_WB = 7;
    localparam logic [1:0] LIM_ABOVE = 2'h1; // value above the limit
    localparam logic [1:0] LIM_BELOW = 2'h2; // value below the limit
    localparam logic [1:0] LIM_EQUAL = 2'h0; // value on the limit
    ////////////////////////////////////////////////////////////////////////
    // reset values and arithmetic
    localparam logic [11:0] CTRL_RST = 12'h004; // factory cal on
    localparam logic [31:0] SCL_GAIN_RST = 32'h0001_0000; // 65536 = unity
    localparam logic [31:0] UCAL_GAIN_RST = 32'h0000_4000; // 2^14 = unity
    localparam logic [15:0] VAL_MAX = 16'h7fff;
    localparam logic [15:0] VAL_MIN = 16'h8000;
    localparam int CAL_SHIFT = 14;
    localparam int SCL_SHIFT = 16;
    // sequencer states, gray from idle through compute time, not on the returns to TCVC_TC
    typedef enum logic [2:0] {
        TCVC_IDLE = 3'h0,
        TCVC_TC = 3'h1,
        TCVC_WB = 3'h3,
        TCVC_CJ = 3'h2,
        TCVC_UPD = 3'h6,
        TCVC_CALC = 3'h7
    } tcvc_state_t;
    // clamp a wide signed value to the signed 16 bit range
    function automatic logic signed [15:0] tcvc_sat16(input logic signed [63:0] x);
        if (x > $signed({{48{1'b0}}, VAL_MAX})) begin
            return VAL_MAX;
        end else if (x < $signed({{48{1'b1}}, VAL_MIN})) begin
            return VAL_MIN;
        end
        return x[15:0];
    endfunction : tcvc_sat16
endpackage : tcvc_pkg

// ---- tcvc_corr_if.sv ----
// carrier between the sequencer and the correction arithmetic
`timescale 1ns/1ps
`default_nettype none
interface tcvc_corr_if;
    logic signed [15:0] raw; // raw converter value
    logic signed [15:0] fofs; // factory offset
    logic signed [31:0] fgain; // factory gain
    logic signed [15:0] uofs; // user calibration offset
    logic signed [31:0] ugain; // user calibration gain
    logic signed [15:0] sofs; // user scaling offset
    logic signed [31:0] sgain; // user scaling gain
    logic fcal_en; // stage enables
    logic ucal_en;
    logic scl_en;
    logic signed [15:0] result; // corrected value
    modport src (output raw, fofs, fgain, uofs, ugain, sofs, sgain,
        fcal_en, ucal_en, scl_en, input result);
    modport eng (input raw, fofs, fgain, uofs, ugain, sofs, sgain,
        fcal_en, ucal_en, scl_en, output result);
endinterface : tcvc_corr_if
`default_nettype wire

// ---- tcvc_corr.sv ----
// fixed point correction chain: factory cal, user cal, user scaling
`timescale 1ns/1ps
`default_nettype none
module tcvc_corr (
    // operands and result
    tcvc_corr_if.eng c
);
    import tcvc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic signed [63:0] fprod; // factory product
    logic signed [63:0] uprod; // user cal product
    logic signed [63:0] sprod; // scaling product
    logic signed [15:0] y_h; // after factory cal
    logic signed [15:0] y_a; // after user cal
    // each stage is bypassed when disabled and clamps instead of wrapping
    always_comb begin
        fprod = (64'(c.raw) - 64'(c.fofs)) * 64'(c.fgain);
        y_h = c.fcal_en ? tcvc_sat16(fprod >>> CAL_SHIFT) : c.raw;
        uprod = (64'(y_h) - 64'(c.uofs)) * 64'(c.ugain);
        y_a = c.ucal_en ? tcvc_sat16(uprod >>> CAL_SHIFT) : y_h;
        // offset counts are in output units, gain 65536 is unity
        sprod = ((64'(y_a) * 64'(c.sgain)) >>> SCL_SHIFT) + 64'(c.sofs);
        c.result = c.scl_en ? tcvc_sat16(sprod) : y_a;
    end
endmodule : tcvc_corr
`default_nettype wire

// ---- tcvc_top.sv ----
// thermocouple value correction: sequencer, registers, limits, flags
//
// Contract
// - overrange sets over and error, clamps 0x7FFF
// - underrange sets under and error, clamps 0x8000
// - error led on at any range fault
// - notch filter always applied, enable ignored
// - filter frequency taken from channel one only
// - higher filter frequency, shorter conversion
// - cycle is channels x three x period plus compute; the code adds one update cycle per channel
// - three measurements per channel each cycle
// - two limit comparisons set limit fields
// - limits are tenths of a degree
// - factory calibration only when enabled
// - scaling offset adds in output units
// - scaling gain 65536 means unity
// - user calibration only when enabled
// - measure continuously, keep readable raw values
// - recompute enabled stages after each acquisition
// - factory value is (raw-offset)*gain/2^14
// - user value is (value-offset)*gain/2^14
// - final is value*gain/2^16 plus offset
// - factory offset and gain are fixed
// - source 2 uses master cold junction value
// - output signed 16 bit tenths of degree
// - no voltage sample during wire test current
`timescale 1ns/1ps
`default_nettype none
module tcvc_top #(
    parameter int NCH = 2, // number of channels
    parameter int unsigned FILT_CYC_A = tcvc_pkg::FILT_CYC_0, // filter periods
    parameter int unsigned FILT_CYC_B = tcvc_pkg::FILT_CYC_1,
    parameter int unsigned FILT_CYC_C = tcvc_pkg::FILT_CYC_2,
    parameter int unsigned FILT_CYC_D = tcvc_pkg::FILT_CYC_3,
    parameter int unsigned CALC_CYCLES = tcvc_pkg::CALC_CYC, // compute time
    parameter logic signed [15:0] TC_VOLTAGE_LIMIT_HI = 16'sh7000, // raw range
    parameter logic signed [15:0] TC_VOLTAGE_LIMIT_LO = -16'sh7000,
    parameter logic [15:0] FCAL_OFS = 16'h0000, // fixed factory data
    parameter logic [31:0] FCAL_GAIN = 32'h0000_4000,
    parameter logic [15:0] FCAL_CJ_OFS = 16'h0000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // converter front end
    input wire logic [15:0] adc_data,
    input wire logic wb_open,
    output logic [1:0] meas_chan,
    output logic [1:0] meas_kind,
    output logic wb_current_en,
    output logic cycle_done,
    // indicator
    output logic error_led
);
    import tcvc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1; // channel index width
    tcvc_state_t st_q; // sequencer state
    tcvc_state_t st_d;
    logic [CW-1:0] ch_q; // channel in progress
    logic [31:0] cnt_q; // cycles spent in a step
    logic [31:0] step_len; // length of the current step
    logic step_end; // last cycle of a step
    logic [11:0] ctrl_q [NCH]; // control per channel
    logic [15:0] lim1_q [NCH]; // limit 1, tenths of degree
    logic [15:0] lim2_q [NCH]; // limit 2
    logic [15:0] sofs_q [NCH]; // user scaling offset
    logic [31:0] sgain_q [NCH]; // user scaling gain
    logic [15:0] uofs_q [NCH]; // user cal offset
    logic [31:0] ugain_q [NCH]; // user cal gain
    logic [15:0] extcj_q [NCH]; // cold junction from master
    logic [15:0] raw_tc_q [NCH]; // raw tc voltage
    logic [15:0] raw_cj_q [NCH]; // raw cold junction
    logic [15:0] value_q [NCH]; // process value
    logic [7:0] stat_q [NCH]; // status byte
    logic [31:0] rdata_q; // read data
    logic [CW-1:0] reg_ch; // channel addressed
    logic reg_ch_ok; // address hits a channel
    logic signed [15:0] cj_temp; // cold junction temperature
    logic signed [15:0] proc_val; // value with cold junction
    logic over_now; // range faults of the channel in work
    logic under_now;
    logic [NCH-1:0] fault_vec; // range fault per channel
    tcvc_corr_if corr ();

    // period of one filter step for a two bit frequency code
    function automatic logic [31:0] filt_len(input logic [1:0] code);
        case (code)
            2'h0: return 32'(FILT_CYC_A);
            2'h1: return 32'(FILT_CYC_B);
            2'h2: return 32'(FILT_CYC_C);
            default: return 32'(FILT_CYC_D);
        endcase
    endfunction : filt_len

    // compare a value against a limit in the same tenths scale
    function automatic logic [1:0] lim_cmp(input logic [15:0] v, input logic [15:0] l);
        if ($signed(v) > $signed(l)) begin
            return LIM_ABOVE;
        end else if ($signed(v) < $signed(l)) begin
            return LIM_BELOW;
        end
        return LIM_EQUAL;
    endfunction : lim_cmp

    ////////////////////////////////////////////////////////////////////////
    // sequencer: per channel three filtered steps, then compute time

    // step length: filter period from channel one only, filter always on
    always_comb begin
        if (st_q == TCVC_CALC) begin
            step_len = 32'(CALC_CYCLES);
        end else if (st_q == TCVC_TC || st_q == TCVC_WB || st_q == TCVC_CJ) begin
            step_len = filt_len(ctrl_q[0][CTRL_FILT_LO +: 2]);
        end else begin
            step_len = 32'h0000_0001; // idle and update last one cycle
        end
        step_end = (cnt_q >= step_len - 32'h0000_0001);
    end

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            TCVC_IDLE: begin
                st_d = TCVC_TC;
            end
            TCVC_TC: begin
                if (step_end) begin
                    st_d = TCVC_WB;
                end
            end
            TCVC_WB: begin
                if (step_end) begin
                    st_d = TCVC_CJ;
                end
            end
            TCVC_CJ: begin
                if (step_end) begin
                    st_d = TCVC_UPD;
                end
            end
            TCVC_UPD: begin
                // last channel goes to compute time, others continue
                st_d = (ch_q == CW'(NCH - 1)) ? TCVC_CALC : TCVC_TC;
            end
            TCVC_CALC: begin
                if (step_end) begin
                    st_d = TCVC_TC;
                end
            end
            default: begin
                st_d = TCVC_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= TCVC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // step counter restarts on every state change
    always_ff @(posedge clk) begin
        if (rst || st_d != st_q) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // channel index advances after each update
    always_ff @(posedge clk) begin
        if (rst) begin
            ch_q <= '0;
        end else if (st_q == TCVC_UPD) begin
            ch_q <= (ch_q == CW'(NCH - 1)) ? '0 : ch_q + CW'(1);
        end
    end

    // front end steering
    assign meas_chan = 2'(ch_q);
    assign meas_kind = (st_q == TCVC_TC) ? 2'h1 : (st_q == TCVC_WB) ? 2'h2 : (st_q == TCVC_CJ) ? 2'h3 : 2'h0;
    assign wb_current_en = (st_q == TCVC_WB);
    assign cycle_done = (st_q == TCVC_CALC) && step_end;

    ////////////////////////////////////////////////////////////////////////
    // raw capture at the end of the voltage and cold junction steps

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                raw_tc_q[i] <= 16'h0000;
                raw_cj_q[i] <= 16'h0000;
            end
        end else if (step_end) begin
            // the tc voltage is taken only in its own step, never while
            // the wire test current flows
            if (st_q == TCVC_TC) begin
                raw_tc_q[ch_q] <= adc_data;
            end
            if (st_q == TCVC_CJ) begin
                raw_cj_q[ch_q] <= adc_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // correction of the channel in work

    // operands of the arithmetic, factory data fixed by parameters
    always_comb begin
        corr.raw = raw_tc_q[ch_q];
        corr.fofs = FCAL_OFS;
        corr.fgain = FCAL_GAIN;
        corr.uofs = uofs_q[ch_q];
        corr.ugain = ugain_q[ch_q];
        corr.sofs = sofs_q[ch_q];
        corr.sgain = sgain_q[ch_q];
        corr.fcal_en = ctrl_q[ch_q][CTRL_FCAL_EN];
        corr.ucal_en = ctrl_q[ch_q][CTRL_UCAL_EN];
        corr.scl_en = ctrl_q[ch_q][CTRL_SCL_EN];
    end

    tcvc_corr tcvc_corr_i (
        .c(corr.eng)
    );

    // cold junction from master or from the own measurement
    always_comb begin
        if (ctrl_q[ch_q][CTRL_CJ_LO +: 2] == CJ_SRC_EXT) begin
            cj_temp = extcj_q[ch_q];
        end else if (ctrl_q[ch_q][CTRL_FCAL_EN]) begin
            cj_temp = tcvc_sat16(64'($signed(raw_cj_q[ch_q])) - 64'($signed(FCAL_CJ_OFS)));
        end else begin
            cj_temp = raw_cj_q[ch_q];
        end
        proc_val = tcvc_sat16(64'(corr.result) + 64'(cj_temp));
        over_now = $signed(raw_tc_q[ch_q]) > TC_VOLTAGE_LIMIT_HI;
        under_now = $signed(raw_tc_q[ch_q]) < TC_VOLTAGE_LIMIT_LO;
    end

    // result and status update once per channel per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                value_q[i] <= 16'h0000;
                stat_q[i] <= 8'h00;
            end
        end else if (st_q == TCVC_UPD) begin
            // past the range the value is forced to the clamp value
            if (over_now) begin
                value_q[ch_q] <= VAL_MAX;
            end else if (under_now) begin
                value_q[ch_q] <= VAL_MIN;
            end else begin
                value_q[ch_q] <= proc_val;
            end
            stat_q[ch_q][ST_OVER] <= over_now;
            stat_q[ch_q][ST_UNDER] <= under_now;
            stat_q[ch_q][ST_ERR] <= over_now | under_now | wb_open;
            stat_q[ch_q][ST_WB] <= wb_open;
            stat_q[ch_q][ST_LIM1_LO +: 2] <= lim_cmp(proc_val, lim1_q[ch_q]);
            stat_q[ch_q][ST_LIM2_LO +: 2] <= lim_cmp(proc_val, lim2_q[ch_q]);
        end
    end

    // red indicator follows any range fault
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fault_vec[i] = stat_q[i][ST_OVER] | stat_q[i][ST_UNDER];
        end
    end
    assign error_led = |fault_vec;

    ////////////////////////////////////////////////////////////////////////
    // register port

    // address decode: upper nibble is the channel
    assign reg_ch = CW'(reg_addr[7:4]);
    assign reg_ch_ok = (reg_addr[7:4] < 4'(NCH));

    // software writable configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_q[i] <= CTRL_RST;
                lim1_q[i] <= 16'h0000;
                lim2_q[i] <= 16'h0000;
                sofs_q[i] <= 16'h0000;
                sgain_q[i] <= SCL_GAIN_RST;
                uofs_q[i] <= 16'h0000;
                ugain_q[i] <= UCAL_GAIN_RST;
                extcj_q[i] <= 16'h0000;
            end
        end else if (reg_wr && reg_ch_ok) begin
            case (reg_addr[3:0])
                REG_CTRL: ctrl_q[reg_ch] <= reg_wdata[11:0];
                REG_LIM1: lim1_q[reg_ch] <= reg_wdata[15:0];
                REG_LIM2: lim2_q[reg_ch] <= reg_wdata[15:0];
                REG_SCL_OFS: sofs_q[reg_ch] <= reg_wdata[15:0];
                REG_SCL_GAIN: sgain_q[reg_ch] <= reg_wdata;
                REG_UCAL_OFS: uofs_q[reg_ch] <= reg_wdata[15:0];
                REG_UCAL_GAIN: ugain_q[reg_ch] <= reg_wdata;
                REG_EXT_CJ: extcj_q[reg_ch] <= reg_wdata[15:0];
                default: begin
                    // read only and unmapped: write ignored
                end
            endcase
        end
    end

    // read data, valid the cycle after the strobe, zero elsewhere
    always_ff @(posedge clk) begin
        if (rst || !reg_rd || !reg_ch_ok) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            case (reg_addr[3:0])
                REG_CTRL: rdata_q <= {20'h0_0000, ctrl_q[reg_ch]};
                REG_LIM1: rdata_q <= {16'h0000, lim1_q[reg_ch]};
                REG_LIM2: rdata_q <= {16'h0000, lim2_q[reg_ch]};
                REG_SCL_OFS: rdata_q <= {16'h0000, sofs_q[reg_ch]};
                REG_SCL_GAIN: rdata_q <= sgain_q[reg_ch];
                REG_UCAL_OFS: rdata_q <= {16'h0000, uofs_q[reg_ch]};
                REG_UCAL_GAIN: rdata_q <= ugain_q[reg_ch];
                REG_EXT_CJ: rdata_q <= {16'h0000, extcj_q[reg_ch]};
                REG_STATUS: rdata_q <= {24'h00_0000, stat_q[reg_ch]};
                REG_VALUE: rdata_q <= {16'h0000, value_q[reg_ch]};
                REG_RAW_TC: rdata_q <= {16'h0000, raw_tc_q[reg_ch]};
                REG_RAW_CJ: rdata_q <= {16'h0000, raw_cj_q[reg_ch]};
                REG_FCAL_OFS: rdata_q <= {16'h0000, FCAL_OFS};
                REG_FCAL_GAIN: rdata_q <= FCAL_GAIN;
                REG_FCAL_CJ: rdata_q <= {16'h0000, FCAL_CJ_OFS};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign reg_rdata = rdata_q;
endmodule : tcvc_top
`default_nettype wire

// ---- tcvc_asserts.sv ----
// port assertions of the value correction top
`timescale 1ns/1ps
`default_nettype none
module tcvc_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // front end side
    input wire logic [1:0] meas_chan,
    input wire logic [1:0] meas_kind,
    input wire logic wb_current_en,
    input wire logic cycle_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // entry into each measurement step
    sequence tc_go;
        $changed(meas_kind) && meas_kind == 2'h1;
    endsequence
    sequence wb_go;
        $changed(meas_kind) && meas_kind == 2'h2;
    endsequence
    sequence cj_go;
        $changed(meas_kind) && meas_kind == 2'h3;
    endsequence
    wb_only_a: assert property (wb_current_en == (meas_kind == 2'h2))
        else $error("test current outside wire step");
    tc_step_a: assert property (tc_go |-> (meas_kind == 2'h1) [*2] ##[1:8] wb_go)
        else $error("voltage step order");
    wb_step_a: assert property (wb_go |-> wb_current_en [*2] ##[1:8] cj_go)
        else $error("wire step order");
    cj_step_a: assert property (cj_go |-> (meas_kind == 2'h3) [*2] ##[1:8] meas_kind == 2'h0)
        else $error("cj step");
    done_pulse_a: assert property (cycle_done |=> !cycle_done) else $error("cycle done too long");
    done_calc_a: assert property (cycle_done |-> $past(meas_kind, 6) == 2'h3 && $past(meas_kind, 5) == 2'h0)
        else $error("compute time length");
    restart_a: assert property (cycle_done |-> ##[1:2] meas_kind == 2'h1) else $error("no restart");
    chan_hold_a: assert property (meas_kind != 2'h0 && $stable(meas_kind) |-> $stable(meas_chan))
        else $error("channel moved in step");
endmodule : tcvc_asserts
bind tcvc_top tcvc_asserts tcvc_asserts_i (.clk(clk), .rst(rst), .meas_chan(meas_chan), .meas_kind(meas_kind),
    .wb_current_en(wb_current_en), .cycle_done(cycle_done));
`default_nettype wire

// ---- tcvc_fe_model.sv ----
// converter front end model answering each measurement step
`timescale 1ns/1ps
`default_nettype none
module tcvc_fe_model (
    // clock
    input wire logic clk,
    // step in progress
    input wire logic [1:0] meas_kind,
    input wire logic wb_current_en,
    // values to present
    input wire logic [15:0] tc_val,
    input wire logic [15:0] cj_val,
    input wire logic wb_break,
    // converter outputs
    output logic [15:0] adc_data,
    output logic wb_open
);
    logic [15:0] junk_q = 16'h1234; // moves every cycle so a stray sample shows
    always_ff @(posedge clk) begin
        junk_q <= junk_q + 16'h3b1d;
    end
    // no voltage while test current flows
    assign adc_data = (meas_kind == 2'h1 && !wb_current_en) ? tc_val : (meas_kind == 2'h3) ? cj_val : junk_q;
    assign wb_open = wb_break; // level seen by the wire check
endmodule : tcvc_fe_model
`default_nettype wire

// ---- tcvc_top_tb.sv ----
// self-checking bench of the value correction top
`timescale 1ns/1ps
`default_nettype none
module tcvc_top_tb;
    import tcvc_pkg::*;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, led, done, wbc, wbo, wbk = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, r, d;
    logic [15:0] adc, tc = 0, cj = 0;
    logic [1:0] mch, mk;
    logic [15:0] rg [2] = '{16'h7100, 16'h8f00};
    int n_fail = 0, n_tests = 0, cyc = 0, t0, v, en, ex, ug, uo, sg, so, ec, ct;
    initial forever #2.5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            final_report();
        end
    end
    // two channels by default, short filter periods and compute time
    tcvc_top #(.FILT_CYC_A(8), .FILT_CYC_B(6), .FILT_CYC_C(4), .FILT_CYC_D(2), .CALC_CYCLES(5)) tcvc_top_i (
        .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .adc_data(adc), .wb_open(wbo), .meas_chan(mch), .meas_kind(mk),
        .wb_current_en(wbc), .cycle_done(done), .error_led(led));
    tcvc_fe_model tcvc_fe_model_i (.clk(clk), .meas_kind(mk), .wb_current_en(wbc), .tc_val(tc), .cj_val(cj),
        .wb_break(wbk), .adc_data(adc), .wb_open(wbo));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input int x);
        @(posedge clk);
        addr <= a;
        wdata <= 32'(x);
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic wdone(input int n);
        // look after the edge, once the pulse has settled
        repeat (n) begin
            @(posedge clk);
            #1;
            while (done !== 1'b1) begin
                @(posedge clk);
                #1;
            end
        end
    endtask : wdone
    task automatic per(input int base);
        wdone(1);
        t0 = cyc;
        wdone(1);
        chk("period", 32'(cyc - t0), 32'(base));
    endtask : per
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nx
    function automatic longint sat(input longint x);
        return x > 32767 ? 32767 : x < -32768 ? -32768 : x;
    endfunction : sat
    // expected value through the enabled stages
    function automatic logic [31:0] ev();
        longint y = $signed(tc);
        if (en[2]) y = sat((y * 16384) >>> 14);
        if (en[1]) y = sat(((y - uo) * ug) >>> 14);
        if (en[0]) y = sat(((y * sg) >>> 16) + so);
        return {16'h0, 16'(sat(y + (ex ? ec : cj)))};
    endfunction : ev
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        r = 32'h0000_71ae;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00); chk("ctrl", d, 32'h0000_0004);
        rd(8'h04); chk("scl gain", d, 32'h0001_0000);
        wr(8'h0d, 0);
        rd(8'h0d); chk("fcal gain", d, 32'h0000_4000);
        rd(8'h30); chk("unmapped", d, 32'h0000_0000);
        per(55);
        wr(8'h10, 32'h0000_0304);
        per(55);
        wr(8'h00, 32'h0000_030c);
        wdone(1);
        per(19);
        wr(8'h00, 32'h0000_0104);
        wdone(1);
        per(43);
        wr(8'h00, 32'h0000_0204);
        wdone(1);
        per(31);
        $display("done: timing");
        repeat (8) begin
            r = nx(nx(r));
            en = r[2:0];
            ex = r[3];
            ug = 32'h3000 + r[15:4];
            uo = r[23:16];
            ec = r[31:24];
            wr(8'h00, 32'h300 + (ex ? 32'h20 : 0) + en);
            wr(8'h05, uo);
            wr(8'h06, ug);
            wr(8'h07, ec);
            r = nx(nx(r));
            so = $signed(r[7:0]);
            sg = 32'h8000 + r[31:16];
            wr(8'h03, so);
            wr(8'h04, sg);
            tc <= {{3{r[20]}}, r[20:8]};
            cj <= 16'(r[15:8]);
            wdone(2);
            rd(8'h09); chk("value", d, ev());
            rd(8'h0a); chk("raw", d, {16'h0, tc});
        end
        $display("done: chain");
        foreach (rg[i]) begin
            tc <= rg[i];
            wdone(2);
            rd(8'h09); chk("clamp", d, {16'h0, rg[i][15] ? VAL_MIN : VAL_MAX});
            rd(8'h08); chk("range", d & 32'h43, rg[i][15] ? 32'h41 : 32'h42);
            chk("led on", 32'(led), 32'h1);
        end
        wr(8'h00, 32'h0000_0304);
        wr(8'h01, 300);
        wr(8'h02, 32'h0000_fed4);
        cj <= 16'd10;
        for (v = 190; v < 400; v += 100) begin
            tc <= 16'(v);
            wdone(2);
            rd(8'h08);
            chk("limits", d[5:2], {LIM_ABOVE, v > 290 ? LIM_ABOVE : v < 290 ? LIM_BELOW : LIM_EQUAL});
        end
        // an open wire flags error and break but leaves the led dark
        wbk <= 1'b1;
        wdone(2);
        rd(8'h08);
        chk("wire break", d & 32'hc0, 32'hc0);
        chk("led off", 32'(led), 32'h0);
        $display("done: limits");
        final_report();
    end
endmodule : tcvc_top_tb
`default_nettype wire
